// ---- core/fbi_pkg.sv ----
// Purpose: Shared constants, types and pin carrier for the flash bus host.
// Assumes: 200 MHz clock; flash pins reached through 2-flop input syncs.
// Notes:   Register index map of the host's own software port.
package fbi_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------------
  // Software register indices
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_CFG    = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RDATA  = 4'h5;

  // Configuration bits and their value after reset.
  localparam int CFG_BYTE_BIT  = 0;
  localparam int CFG_BOOT_BIT  = 1;
  localparam int CFG_RPHV_BIT  = 2;
  localparam int CFG_PWRDN_BIT = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // Status bits.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NRA_BIT  = 1;

  // ----------------------------------------------------------------------
  // Flash command codes, always on the low data byte
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP   = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SYNC_STAGES   = 2;
  localparam int T_ACC_NS      = 90;
  localparam int T_WP_NS       = 50;
  localparam int T_SU_NS       = 10;
  localparam int T_REC_NS      = 20;
  // Read strobe also covers the output register and the input syncs.
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS + SYNC_STAGES + 1);
  localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS);
  localparam logic [7:0] SU_CYC  = 8'((T_SU_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS);
  localparam logic [7:0] REC_CYC = 8'((T_REC_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_READ       = 3'b001,
    OP_PROGRAM    = 3'b010,
    OP_ERASE      = 3'b011,
    OP_READ_ARRAY = 3'b100,
    OP_ID_READ    = 3'b101
  } fbi_op_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETUP   = 2'b01,
    ST_STROBE  = 2'b10,
    ST_RECOVER = 2'b11
  } fbi_state_t;

  // ----------------------------------------------------------------------
  // Pins driven toward the flash
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              reset_powerdown_n;
    logic              rp_unlock_hv_en;
    logic              program_supply_en;
    logic              boot_unlock_pin;
    logic              chip_select_n;
    logic              output_enable_n;
    logic              write_enable_n;
    logic              byte_width_select;
    logic              id_hv_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dq_oe_n;
  } fbi_pins_t;

  localparam fbi_pins_t PINS_RESET = '{
    reset_powerdown_n: 1'b0, rp_unlock_hv_en: 1'b0,
    program_supply_en: 1'b0, boot_unlock_pin: 1'b0,
    chip_select_n: 1'b1, output_enable_n: 1'b1, write_enable_n: 1'b1,
    byte_width_select: 1'b1, id_hv_en: 1'b0,
    addr: 19'h00000, dq_o: 16'h0000, dq_oe_n: 16'hFFFF};

endpackage

// ---- core/fbi_host.sv ----
// Purpose: Host controller that drives a parallel boot-block flash.
// Assumes: One 200 MHz clock; flash data inputs arrive asynchronously.
// Notes:   Software issues one operation at a time through REG_CTRL.
`timescale 1ns/1ps

// Summary of operation
// - Erase writes 20h then D0h to the block, program supply on.
// - Program writes setup code 40h then address and data, supply on.
// - After program or erase, FFh is written before any array read.
// - During id reads every address line but the lowest is held low.
// - Command codes travel only on the low eight data lines.
module fbi_host
  import fbi_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Software register port.
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // Flash pins.
  output fbi_pins_t              pins,
  input  wire logic [DATA_W-1:0] dq_i
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  fbi_state_t        st_q,    st_d;
  fbi_op_t           op_q,    op_d;
  logic              step_q,  step_d;
  logic [7:0]        cnt_q,   cnt_d;
  logic [19:0]       addr_q,  addr_d;
  logic [15:0]       wdata_q, wdata_d;
  logic [3:0]        cfg_q,   cfg_d;
  logic              nra_q,   nra_d;
  logic [15:0]       rcap_q,  rcap_d;
  logic [15:0]       rdat_q,  rdat_d;
  fbi_pins_t         pins_q,  pins_d;
  logic [DATA_W-1:0] dq_m_q,  dq_s_q;

  logic              cyc_we;
  logic              cyc_last;
  logic [15:0]       cyc_data;
  logic              byte_md;

  // Whether a given step of an operation is a write cycle.
  function automatic logic step_is_write(fbi_op_t op, logic step);
    step_is_write = !(step && (op == OP_READ || op == OP_ID_READ));
  endfunction

  // Read-array ends at step zero; every other operation ends at step one.
  function automatic logic step_is_last(fbi_op_t op, logic step);
    step_is_last = step || (op == OP_READ_ARRAY);
  endfunction

  // Data driven in a write step; codes occupy the low byte only.
  function automatic logic [15:0] step_data(fbi_op_t op, logic step,
                                            logic [15:0] wd);
    logic [7:0] code;
    code = CMD_READ_ARRAY;
    if (!step && op == OP_PROGRAM) code = CMD_WRITE_SETUP;
    if (!step && op == OP_ERASE)   code = CMD_ERASE_SETUP;
    if (step && op == OP_ERASE)    code = CMD_ERASE_CONFIRM;
    if (step && op == OP_PROGRAM)
      step_data = wd;
    else
      step_data = {8'h00, code};
  endfunction

  assign byte_md  = cfg_q[CFG_BYTE_BIT];
  assign cyc_we   = step_is_write(op_q, step_q);
  assign cyc_last = step_is_last(op_q, step_q);
  assign cyc_data = step_data(op_q, step_q, wdata_q);

  assign pins      = pins_q;
  assign reg_rdata = rdat_q;

  // ----------------------------------------------------------------------
  // Next-state logic: registers, sequencer and pins
  // ----------------------------------------------------------------------
  // Computes every next value of the controller from the current state.
  always_comb
  begin
    st_d    = st_q;
    op_d    = op_q;
    step_d  = step_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    cfg_d   = cfg_q;
    nra_d   = nra_q;
    rcap_d  = rcap_q;
    rdat_d  = rdat_q;

    // Register writes; CTRL starts an operation only while idle.
    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_ADDR:  addr_d  = {reg_wdata[3:0], reg_wdata};
        REG_WDATA: wdata_d = reg_wdata;
        REG_CFG:   cfg_d   = reg_wdata[3:0];
        default:   ;
      endcase
    end

    // Register reads answer in the following cycle.
    rdat_d = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_ADDR:   rdat_d = addr_q[15:0];
        REG_WDATA:  rdat_d = wdata_q;
        REG_CFG:    rdat_d = {12'h000, cfg_q};
        REG_STATUS: rdat_d = {14'h0000, nra_q, st_q != ST_IDLE};
        REG_RDATA:  rdat_d = rcap_q;
        default:    rdat_d = 16'h0000;
      endcase
    end

    unique case (st_q)
      ST_IDLE:
      begin
        if (reg_wr && reg_addr == REG_CTRL
            && reg_wdata[2:0] inside {3'b001, 3'b010, 3'b011,
                                      3'b100, 3'b101})
        begin
          op_d   = fbi_op_t'(reg_wdata[2:0]);
          // An array read is preceded by FFh while one is owed.
          step_d = (op_d == OP_ID_READ)
                   || (op_d == OP_READ && !nra_q);
          st_d   = ST_SETUP;
          cnt_d  = SU_CYC - 8'h01;
        end
      end
      ST_SETUP:
      begin
        if (cnt_q == 8'h00)
        begin
          st_d  = ST_STROBE;
          cnt_d = (cyc_we ? WP_CYC : ACC_CYC) - 8'h01;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      ST_STROBE:
      begin
        if (cnt_q == 8'h00)
        begin
          // Byte mode reads return only the low byte.
          if (!cyc_we)
            rcap_d = byte_md ? {8'h00, dq_s_q[7:0]} : dq_s_q;
          st_d  = ST_RECOVER;
          cnt_d = REC_CYC - 8'h01;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      ST_RECOVER:
      begin
        if (cnt_q == 8'h00)
        begin
          if (cyc_we && cyc_data == {8'h00, CMD_READ_ARRAY})
            nra_d = 1'b0;
          if (cyc_last && (op_q == OP_PROGRAM || op_q == OP_ERASE))
            nra_d = 1'b1;
          if (cyc_last)
            st_d = ST_IDLE;
          else
          begin
            step_d = 1'b1;
            st_d   = ST_SETUP;
            cnt_d  = SU_CYC - 8'h01;
          end
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
    endcase

    // Pins: power-down and boot unlock levels come straight from CFG; RP unlock is masked in power-down.
    pins_d = PINS_RESET;
    pins_d.reset_powerdown_n = !cfg_q[CFG_PWRDN_BIT];
    pins_d.rp_unlock_hv_en   = cfg_q[CFG_RPHV_BIT]
                               && !cfg_q[CFG_PWRDN_BIT];
    pins_d.boot_unlock_pin   = cfg_q[CFG_BOOT_BIT];
    pins_d.byte_width_select = !byte_md;
    if (st_q != ST_IDLE)
    begin
      // Supply stays up across setup and confirm cycles.
      pins_d.program_supply_en = (op_q == OP_PROGRAM)
                                 || (op_q == OP_ERASE);
      pins_d.chip_select_n   = (st_q == ST_RECOVER);
      pins_d.write_enable_n  = !(cyc_we && st_q == ST_STROBE);
      pins_d.output_enable_n = !(!cyc_we && st_q == ST_STROBE);
      if (op_q == OP_ID_READ)
      begin
        pins_d.addr     = {18'h00000, addr_q[1]};
        pins_d.id_hv_en = 1'b1;
      end
      else
        pins_d.addr = addr_q[19:1];
      if (cyc_we)
      begin
        pins_d.dq_o            = cyc_data;
        pins_d.dq_oe_n[7:0]    = 8'h00;
        pins_d.dq_oe_n[15:8]   = byte_md ? 8'hFF : 8'h00;
      end
      // In byte mode line fifteen carries the byte address.
      if (byte_md)
      begin
        pins_d.dq_o[15]    = addr_q[0];
        pins_d.dq_oe_n[15] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Holds the controller state; pins leave from flip-flops.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q    <= ST_IDLE;
      op_q    <= OP_NONE;
      step_q  <= 1'b0;
      cnt_q   <= 8'h00;
      addr_q  <= 20'h00000;
      wdata_q <= 16'h0000;
      cfg_q   <= CFG_RESET;
      nra_q   <= 1'b0;
      rcap_q  <= 16'h0000;
      rdat_q  <= 16'h0000;
      pins_q  <= PINS_RESET;
    end
    else
    begin
      st_q    <= st_d;
      op_q    <= op_d;
      step_q  <= step_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      cfg_q   <= cfg_d;
      nra_q   <= nra_d;
      rcap_q  <= rcap_d;
      rdat_q  <= rdat_d;
      pins_q  <= pins_d;
    end
  end

  // Two-stage synchroniser for the flash data lines.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end
    else
    begin
      dq_m_q <= dq_i;
      dq_s_q <= dq_m_q;
    end
  end

endmodule

// ---- tb/fbi_host_properties.sv ----
// Purpose: Pin level and ordering checks on the flash host.
// Assumes: One clock domain; bound to fbi_host.
// Notes:   Sees only the ports of the host.
`timescale 1ns/1ps
module fbi_host_properties
  import fbi_pkg::*;
(
  // Clock and reset.
  input wire logic      clk,
  input wire logic      rst,
  // Flash pins.
  input wire fbi_pins_t pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] arm_q;
  logic       we_q;
  logic       wfall;
  assign wfall = we_q && !pins.write_enable_n;
  // Tracks which setup code went before the next write cycle.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      arm_q <= 2'd0;
      we_q  <= 1'b1;
    end
    else
    begin
      we_q <= pins.write_enable_n;
      if (wfall)
        arm_q <= (arm_q != 2'd0) ? 2'd0 :
                 (pins.dq_o[7:0] == CMD_ERASE_SETUP) ? 2'd1 :
                 (pins.dq_o[7:0] == CMD_WRITE_SETUP) ? 2'd2 : 2'd0;
    end
  property p_strobe_excl;
    !(!pins.write_enable_n && !pins.output_enable_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("write and output enables low together");
  property p_we_sel;
    !pins.write_enable_n |-> !pins.chip_select_n && pins.reset_powerdown_n;
  endproperty
  a_we_sel: assert property (p_we_sel)
    else $error("write strobe without select");
  property p_oe_float;
    !pins.output_enable_n |-> pins.dq_oe_n[14:0] == 15'h7FFF &&
      (pins.dq_oe_n[15] || !pins.byte_width_select);
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("host drives data during read");
  property p_we_drive;
    !pins.write_enable_n |-> pins.dq_oe_n[7:0] == 8'h00;
  endproperty
  a_we_drive: assert property (p_we_drive)
    else $error("low data byte not driven in write");
  property p_erase_pair;
    wfall && arm_q == 2'd1 |->
      pins.dq_o[7:0] == CMD_ERASE_CONFIRM && pins.program_supply_en;
  endproperty
  a_erase_pair: assert property (p_erase_pair)
    else $error("erase setup not followed by confirm");
  property p_write_vpp;
    wfall && arm_q == 2'd2 |-> pins.program_supply_en [*3];
  endproperty
  a_write_vpp: assert property (p_write_vpp)
    else $error("program cycle without supply");
  property p_id_addr;
    pins.id_hv_en && !pins.output_enable_n |-> pins.addr[18:1] == 18'h00000;
  endproperty
  a_id_addr: assert property (p_id_addr)
    else $error("address lines high in id read");
  property p_byte_float;
    !pins.byte_width_select && !pins.chip_select_n |->
      pins.dq_oe_n[14:8] == 7'h7F;
  endproperty
  a_byte_float: assert property (p_byte_float)
    else $error("middle lines driven in byte mode");
  property p_rp_unlock;
    pins.rp_unlock_hv_en |-> pins.reset_powerdown_n;
  endproperty
  a_rp_unlock: assert property (p_rp_unlock)
    else $error("unlock voltage with reset pin low");
  c_erase: cover property (wfall && arm_q == 2'd1);
  c_id: cover property (pins.id_hv_en && !pins.output_enable_n);
  c_byte: cover property (!pins.byte_width_select && wfall);
endmodule
bind fbi_host fbi_host_properties u_props (.clk(clk), .rst(rst), .pins(pins));

// ---- tb/fbi_flash_model.sv ----
// Purpose: Behavioural top-boot flash answering the host pins.
// Assumes: Commands latch as the selected write strobe ends.
// Notes:   Released lines show the inverse of the last value.
`timescale 1ns/1ps
module fbi_flash_model
  import fbi_pkg::*;
#(
  // Identification values are arbitrary.
  parameter logic [7:0] MFR_CODE  = 8'hA5,
  parameter logic [7:0] MFR_UPPER = 8'h4B,
  parameter logic [7:0] DEV_CODE  = 8'h5A,
  parameter logic [7:0] DEV_UPPER = 8'h3C
)
(
  // Pins from the host.
  input  wire fbi_pins_t    pins,
  // Data lines back to the host.
  output logic [DATA_W-1:0] dq_i
);
  logic [15:0] mem [int];
  logic [15:0] rd;
  logic [15:0] w;
  logic [15:0] last = 16'h0000;
  logic [15:0] dmask;
  logic [7:0]  stat = 8'h80;
  logic [1:0]  mode = 2'd0;
  logic [1:0]  arm = 2'd0;
  logic        ok;
  int          q [$];
  logic [1:0]  prev;
  logic        wact;
  // Select and write enable may rise together, so latch on their joint end.
  assign wact = pins.reset_powerdown_n && !pins.chip_select_n &&
                !pins.write_enable_n;
  function automatic int blk(input int a);
    return (a[18:16] == 3'h7) ? 8 + a[15:13] : a[18:16];
  endfunction
  function automatic logic [15:0] rdm(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  // Command decoder; the boot block needs an unlock condition.
  always @(negedge wact or negedge pins.reset_powerdown_n)
  begin
    ok = pins.program_supply_en && (blk(pins.addr) != 15 ||
         pins.rp_unlock_hv_en || pins.boot_unlock_pin);
    if (!pins.reset_powerdown_n)
    begin
      mode = 2'd0;
      arm = 2'd0;
      stat = 8'h80;
    end
    else
    begin
      prev = arm;
      case (arm)
        2'd1:
        begin
          q = {};
          foreach (mem[k])
            if (blk(k) == blk(pins.addr))
              q.push_back(k);
          if (ok && pins.dq_o[7:0] == CMD_ERASE_CONFIRM)
            foreach (q[j])
              mem.delete(q[j]);
          else
            stat = 8'hA0;
        end
        2'd2:
        begin
          w = rdm(pins.addr);
          if (pins.byte_width_select)
            w = w & pins.dq_o;
          else
            w[{pins.dq_o[15], 3'b000} +: 8] &= pins.dq_o[7:0];
          if (ok)
            mem[pins.addr] = w;
          else
            stat = 8'h90;
        end
        default:
          case (pins.dq_o[7:0])
            8'h20: arm = 2'd1;
            8'h10, 8'h40: arm = 2'd2;
            8'h90: mode = 2'd2;
            default: mode = 2'd0;
          endcase
      endcase
      // Only the cycle after a setup code ends the pair.
      if (prev != 2'd0)
      begin
        arm = 2'd0;
        mode = 2'd1;
      end
    end
  end
  // Read path: drives only when selected, enabled and not writing.
  always @*
  begin
    rd = {8'h00, stat};
    if (pins.id_hv_en || mode == 2'd2)
      rd = pins.addr[0] ? {DEV_UPPER, DEV_CODE} : {MFR_UPPER, MFR_CODE};
    else if (mode == 2'd0)
      rd = rdm(pins.addr) >> {!pins.byte_width_select && pins.dq_o[15], 3'b000};
    dmask = !(pins.reset_powerdown_n && !pins.chip_select_n &&
      !pins.output_enable_n && pins.write_enable_n) ? 16'h0000 :
      pins.byte_width_select ? 16'hFFFF : 16'h00FF;
  end
  always @(rd or dmask)
    if (dmask != 16'h0000)
      last = rd;
  assign dq_i = (rd & dmask) | (~last & ~dmask);
endmodule

// ---- tb/tb_fbi_host.sv ----
// Purpose: Self-checking bench for the flash host.
// Assumes: 200 MHz clock; the flash model answers the pins.
// Notes:   Random addresses avoid the boot block unless meant.
`timescale 1ns/1ps
module tb_fbi_host;
  import fbi_pkg::*;
  // Identification values are arbitrary.
  localparam logic [7:0] MC = 8'hA5, MU = 8'h4B, DC = 8'h5A, DU = 8'h3C;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] got;
  logic [15:0] a;
  logic [15:0] d;
  fbi_pins_t   pins;
  logic [15:0] dq_i;
  int          err_count = 0;
  int          tests_run = 0;
  always #2.5 clk = ~clk;
  fbi_host u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pins(pins), .dq_i(dq_i));
  fbi_flash_model #(.MFR_CODE(MC), .MFR_UPPER(MU), .DEV_CODE(DC),
    .DEV_UPPER(DU)) u_flash (.pins(pins), .dq_i(dq_i));
  task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  // Starts an operation and polls busy under a bound.
  task automatic op(input logic [15:0] code);
    int n;
    wr(REG_CTRL, code);
    for (n = 0; n < 400; n++)
    begin
      rd(REG_STATUS);
      if (got[STAT_BUSY_BIT] === 1'b0)
        break;
    end
    if (n == 400)
      chk("busy", 16'h0000, 16'h0001);
  endtask
  function automatic logic [15:0] id_exp(input int i);
    logic [7:0] c;
    c = i[0] ? DC : MC;
    return i[1] ? {8'h00, c} : {i[0] ? DU : MU, c};
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end
  initial
  begin
    d = 16'($urandom(31705));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CFG);
    chk("cfg", {12'h000, CFG_RESET}, got);
    rd(4'hF);
    chk("unmapped", 16'h0000, got);
    for (int i = 0; i < 4; i++)
    begin
      a = {2'b00, i[1:0], 12'($urandom)};
      d = 16'($urandom);
      wr(REG_ADDR, a);
      wr(REG_WDATA, d);
      op(16'h0002);
      rd(REG_STATUS);
      chk("nra", 16'h0001, {15'h0, got[STAT_NRA_BIT]});
      op(16'h0001);
      rd(REG_RDATA);
      chk("word", d, got);
    end
    op(16'h0003);
    op(16'h0001);
    rd(REG_RDATA);
    chk("erase", 16'hFFFF, got);
    op(16'h0004);
    rd(REG_STATUS);
    chk("nra clr", 16'h0000, {15'h0, got[STAT_NRA_BIT]});
    for (int i = 0; i < 3; i++)
    begin
      d = 16'($urandom);
      wr(REG_CFG, 16'(2 * i));
      wr(REG_ADDR, 16'hC00F + 16'(16 * i));
      wr(REG_WDATA, d);
      op(16'h0002);
      op(16'h0001);
      rd(REG_RDATA);
      chk("boot", (i == 0) ? 16'hFFFF : d, got);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CFG, {15'h0, i[1]});
      wr(REG_ADDR, {14'h0, i[0], 1'b0});
      op(16'h0005);
      rd(REG_RDATA);
      chk("id", id_exp(i), got);
    end
    d = 16'($urandom);
    wr(REG_ADDR, 16'h4001);
    wr(REG_WDATA, d);
    op(16'h0002);
    op(16'h0001);
    rd(REG_RDATA);
    chk("byte", {8'h00, d[7:0]}, got);
    wr(REG_CFG, 16'h000C);
    rd(REG_CFG);
    chk("pwrdn cfg", 16'h000C, got);
    finish_test();
  end
endmodule
